// ---- hw/usbec_core.sv ----
/*
  Error flag, error enable and endpoint control registers of a dual-role USB
  controller, behind an APB slave. Assumes the protocol engine delivers one-cycle
  error pulses synchronous to pclk and reads the decoded endpoint controls.
*/
// The APB interface to the registers and the address map were decided locally.
`include "usbec_defines.svh"

module usbec_core
  import usbec_pkg::*;
#(
  parameter int EP_COUNT = `USBEC_EP_COUNT
)
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  input  wire usbec_err_s        err_event,
  input  wire logic              bytes_over_count,
  input  wire logic              stall_event,
  input  wire logic [3:0]        stall_ep,
  output usbec_err_s             err_flags,
  output logic                   error_summary_flag,
  output logic                   bus_reset_irq_enable,
  output logic                   detach_irq_enable,
  output logic                   store_truncate,
  output usbec_role_e            role,
  output usbec_ep_s [EP_COUNT-1:0] ep_ctrl
);

  logic [7:0]  irq_en_r;
  logic [7:0]  err_r;
  logic [7:0]  err_en_r;
  logic        role_r;
  logic [7:0]  ep_r [EP_COUNT];
  logic [7:0]  ev_vec;
  logic        wr;
  logic        rd;
  logic [7:0]  wbyte;
  logic        ep_hit;
  logic [3:0]  ep_idx;
  logic        known;
  logic [7:0]  rd_nxt;

  function automatic logic [7:0] ep_view(input logic [7:0] v, input int idx, input logic host);
    ep_view = (idx == 0 && host) ? (v & `USBEC_EP0_MASK) : (v & `USBEC_EPN_MASK);
  endfunction

  assign wr    = psel && penable && pwrite;
  assign rd    = psel && penable && !pwrite;
  assign wbyte = pwdata[7:0];
  assign ep_hit = (paddr >= `USBEC_OFF_EP_BASE) &&
                  (paddr < `USBEC_OFF_EP_BASE + 12'(4 * EP_COUNT)) && (paddr[1:0] == 2'b00);
  assign ep_idx = 4'((paddr - `USBEC_OFF_EP_BASE) >> 2);
  assign known  = ep_hit || paddr == `USBEC_OFF_IRQ_EN || paddr == `USBEC_OFF_ERR_FLAGS ||
                  paddr == `USBEC_OFF_ERR_EN || paddr == `USBEC_OFF_ROLE;

  // Bit 1 takes the CRC5 token error as a device and the end-of-frame error as a host.
  always_comb
  begin
    ev_vec = {err_event.stuff, 1'b0, err_event.overrun, err_event.turnaround,
              err_event.partial, err_event.data_crc,
              role_r ? err_event.frame_end : err_event.token_crc,
              err_event.pid};
  end

  // Zero-filled APB answer with no wait states; unmapped addresses raise pslverr.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !known;
      prdata  <= {24'h00_0000, rd_nxt};
    end
  end

  always_comb
  begin
    rd_nxt = 8'h00;
    if (paddr == `USBEC_OFF_IRQ_EN)
      rd_nxt = irq_en_r;
    else if (paddr == `USBEC_OFF_ERR_FLAGS)
      rd_nxt = err_r;
    else if (paddr == `USBEC_OFF_ERR_EN)
      rd_nxt = err_en_r;
    else if (paddr == `USBEC_OFF_ROLE)
      rd_nxt = {7'h00, role_r};
    else if (ep_hit)
      rd_nxt = ep_view(ep_r[ep_idx], int'(ep_idx), role_r);
  end

  // Writes land on the access cycle while pready is high, which is the sampling edge.
  wire acc_wr = wr && pready;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      err_r <= `USBEC_RESET_BYTE;
    else
      err_r <= ((err_r & ~(acc_wr && paddr == `USBEC_OFF_ERR_FLAGS ? wbyte : 8'h00)) | ev_vec)
               & `USBEC_ERR_MASK;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      err_en_r <= `USBEC_RESET_BYTE;
      irq_en_r <= `USBEC_RESET_BYTE;
      role_r   <= 1'b0;
    end
    else if (acc_wr)
    begin
      if (paddr == `USBEC_OFF_ERR_EN)
        err_en_r <= wbyte & `USBEC_ERR_MASK;
      if (paddr == `USBEC_OFF_IRQ_EN)
        irq_en_r <= wbyte & `USBEC_IRQ_EN_MASK;
      if (paddr == `USBEC_OFF_ROLE)
        role_r <= wbyte[0];
    end
  end

  // The stall bit is status: a stall handshake sets it, and software may clear it by write.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < EP_COUNT; i++)
        ep_r[i] <= `USBEC_RESET_BYTE;
    end
    else
    begin
      for (int i = 0; i < EP_COUNT; i++)
      begin
        if (acc_wr && ep_hit && int'(ep_idx) == i)
          ep_r[i] <= wbyte & ((i == 0) ? `USBEC_EP0_MASK : `USBEC_EPN_MASK);
        if (stall_event && int'(stall_ep) == i)
          ep_r[i][`USBEC_EP_STALLED] <= 1'b1;
      end
    end
  end

  // Summary is sticky and cleared here only through the enable or flag being cleared.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      error_summary_flag   <= 1'b0;
      bus_reset_irq_enable <= 1'b0;
      detach_irq_enable    <= 1'b0;
      store_truncate       <= 1'b0;
      err_flags            <= '0;
      role                 <= USBEC_ROLE_DEVICE;
    end
    else
    begin
      error_summary_flag   <= |(err_r & err_en_r);
      bus_reset_irq_enable <= irq_en_r[0] && !role_r;
      detach_irq_enable    <= irq_en_r[0] && role_r;
      store_truncate       <= bytes_over_count;
      err_flags            <= usbec_err_s'({err_r[7], err_r[5:2],
                                            !role_r && err_r[1], role_r && err_r[1], err_r[0]});
      role                 <= role_r ? USBEC_ROLE_HOST : USBEC_ROLE_DEVICE;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ep_ctrl <= '0;
    else
    begin
      for (int i = 0; i < EP_COUNT; i++)
      begin
        ep_ctrl[i].low_speed     <= (i == 0) && role_r && ep_r[i][`USBEC_EP_LOW_SPEED];
        ep_ctrl[i].nak_retry_off <= (i == 0) && role_r && ep_r[i][`USBEC_EP_NAK_RETRY];
        ep_ctrl[i].rx            <= ep_r[i][`USBEC_EP_RX_EN];
        ep_ctrl[i].tx            <= ep_r[i][`USBEC_EP_TX_EN];
        ep_ctrl[i].setup_ok      <= ep_r[i][`USBEC_EP_RX_EN] && ep_r[i][`USBEC_EP_TX_EN] &&
                                    !ep_r[i][`USBEC_EP_CTRL_DIS];
        ep_ctrl[i].handshake     <= ep_r[i][`USBEC_EP_HSHK_EN];
        ep_ctrl[i].stalled       <= ep_r[i][`USBEC_EP_STALLED];
      end
    end
  end

  property p_stuff_sets;
    @(posedge pclk) disable iff (!presetn) err_event.stuff |=> err_r[7];
  endproperty
  a_stuff_sets: assert property (p_stuff_sets) else $error("stuff flag not set");

  property p_overrun_truncate;
    @(posedge pclk) disable iff (!presetn)
      (err_event.overrun && bytes_over_count) |=> (err_r[5] && store_truncate);
  endproperty
  a_overrun_truncate: assert property (p_overrun_truncate) else $error("overrun not seen");

  property p_bit1_role;
    @(posedge pclk) disable iff (!presetn)
      (err_event.token_crc && !err_event.frame_end && role_r && !err_r[1]) |=> !err_r[1];
  endproperty
  a_bit1_role: assert property (p_bit1_role) else $error("token error seen in host role");

  property p_event_beats_clear;
    @(posedge pclk) disable iff (!presetn)
      (err_event.pid && acc_wr && paddr == `USBEC_OFF_ERR_FLAGS && wbyte[0]) |=> err_r[0];
  endproperty
  a_event_beats_clear: assert property (p_event_beats_clear) else $error("clear beat event");

  property p_w1c;
    @(posedge pclk) disable iff (!presetn)
      (acc_wr && paddr == `USBEC_OFF_ERR_FLAGS && ev_vec == 8'h00) |=>
        err_r == ($past(err_r) & ~$past(wbyte) & `USBEC_ERR_MASK);
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one to clear broken");

  property p_reserved_zero;
    @(posedge pclk) disable iff (!presetn) !err_r[6] && !err_en_r[6];
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

  property p_summary;
    @(posedge pclk) disable iff (!presetn) ##1 error_summary_flag == |$past(err_r & err_en_r);
  endproperty
  a_summary: assert property (p_summary) else $error("summary mismatch");

  property p_setup_gate;
    @(posedge pclk) disable iff (!presetn)
      ##1 ep_ctrl[3].setup_ok |-> ($past(ep_r[3][3]) && $past(ep_r[3][2]) && !$past(ep_r[3][4]));
  endproperty
  a_setup_gate: assert property (p_setup_gate) else $error("setup allowed wrongly");

  property p_low_speed_ep;
    @(posedge pclk) disable iff (!presetn) !ep_ctrl[1].low_speed && !ep_ctrl[1].nak_retry_off;
  endproperty
  a_low_speed_ep: assert property (p_low_speed_ep) else $error("ep1 host bits set");

  property p_turn_sets;
    @(posedge pclk) disable iff (!presetn) err_event.turnaround |=> err_r[4];
  endproperty
  a_turn_sets: assert property (p_turn_sets) else $error("turnaround flag not set");

  property p_partial_sets;
    @(posedge pclk) disable iff (!presetn) err_event.partial |=> err_r[3];
  endproperty
  a_partial_sets: assert property (p_partial_sets) else $error("partial flag not set");

  property p_dcrc_sets;
    @(posedge pclk) disable iff (!presetn) err_event.data_crc |=> err_r[2];
  endproperty
  a_dcrc_sets: assert property (p_dcrc_sets) else $error("data crc flag not set");

  property p_tcrc_dev;
    @(posedge pclk) disable iff (!presetn) (err_event.token_crc && !role_r) |=> err_r[1];
  endproperty
  a_tcrc_dev: assert property (p_tcrc_dev) else $error("token crc flag not set");

  property p_eof_host;
    @(posedge pclk) disable iff (!presetn) (err_event.frame_end && role_r) |=> err_r[1];
  endproperty
  a_eof_host: assert property (p_eof_host) else $error("frame end flag not set");

  property p_pid_sets;
    @(posedge pclk) disable iff (!presetn) err_event.pid |=> err_r[0];
  endproperty
  a_pid_sets: assert property (p_pid_sets) else $error("pid flag not set");

  // Without a clearing write no flag may fall, whatever else the bus does.
  property p_sticky;
    @(posedge pclk) disable iff (!presetn)
      !(acc_wr && paddr == `USBEC_OFF_ERR_FLAGS) |=> (err_r & $past(err_r)) == $past(err_r);
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag fell without a clear");

  property p_enable_write;
    @(posedge pclk) disable iff (!presetn)
      (acc_wr && paddr == `USBEC_OFF_ERR_EN) |=> err_en_r == ($past(wbyte) & `USBEC_ERR_MASK);
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable write lost");

  property p_irq_role;
    @(posedge pclk) disable iff (!presetn)
      ##1 (bus_reset_irq_enable == ($past(irq_en_r[0]) && !$past(role_r))) &&
          (detach_irq_enable == ($past(irq_en_r[0]) && $past(role_r)));
  endproperty
  a_irq_role: assert property (p_irq_role) else $error("irq enable role mismatch");

  property p_ep0_host;
    @(posedge pclk) disable iff (!presetn)
      ##1 (ep_ctrl[0].low_speed == ($past(role_r) && $past(ep_r[0][7]))) &&
          (ep_ctrl[0].nak_retry_off == ($past(role_r) && $past(ep_r[0][6])));
  endproperty
  a_ep0_host: assert property (p_ep0_host) else $error("ep0 host bits");

  property p_ep_dirs;
    @(posedge pclk) disable iff (!presetn)
      ##1 {ep_ctrl[3].rx, ep_ctrl[3].tx, ep_ctrl[3].handshake} ==
          {$past(ep_r[3][3]), $past(ep_r[3][2]), $past(ep_r[3][0])};
  endproperty
  a_ep_dirs: assert property (p_ep_dirs) else $error("ep3 dirs");

  property p_stall_sets;
    @(posedge pclk) disable iff (!presetn) stall_event |=> ep_r[$past(stall_ep)][1];
  endproperty
  a_stall_sets: assert property (p_stall_sets) else $error("stall bit not set");

  property p_ep_write;
    @(posedge pclk) disable iff (!presetn)
      (acc_wr && ep_hit && ep_idx == 4'(EP_COUNT - 1) && !stall_event) |=>
        ep_r[EP_COUNT-1] == ($past(wbyte) & `USBEC_EPN_MASK);
  endproperty
  a_ep_write: assert property (p_ep_write) else $error("last endpoint write lost");

  c_error_flag: cover property (@(posedge pclk) disable iff (!presetn) $rose(error_summary_flag));
  c_clear_write: cover property (@(posedge pclk) disable iff (!presetn)
    acc_wr && paddr == `USBEC_OFF_ERR_FLAGS && err_r != 8'h00);
  c_host_lowspeed: cover property (@(posedge pclk) disable iff (!presetn) ep_ctrl[0].low_speed);
  c_stall: cover property (@(posedge pclk) disable iff (!presetn) ep_ctrl[5].stalled);
  c_ep_read: cover property (@(posedge pclk) disable iff (!presetn) rd && pready && ep_hit);

endmodule

// ---- include/usbec_defines.svh ----
/*
  Register offsets, field positions, reset values and masks of the USB error and
  endpoint control block. Assumes inclusion by bare name from the design.
*/
`ifndef USBEC_DEFINES_SVH
`define USBEC_DEFINES_SVH

`define USBEC_OFF_IRQ_EN     12'h000
`define USBEC_OFF_ERR_FLAGS  12'h004
`define USBEC_OFF_ERR_EN     12'h008
`define USBEC_OFF_ROLE       12'h00C
`define USBEC_OFF_EP_BASE    12'h040
`define USBEC_EP_COUNT       16
`define USBEC_ERR_MASK       8'hBF
`define USBEC_EP0_MASK       8'hDF
`define USBEC_EPN_MASK       8'h1F
`define USBEC_IRQ_EN_MASK    8'hFF
`define USBEC_RESET_BYTE     8'h00
`define USBEC_BIT_STUFF      7
`define USBEC_BIT_OVERRUN    5
`define USBEC_BIT_TURNAROUND 4
`define USBEC_BIT_PARTIAL    3
`define USBEC_BIT_DATA_CRC   2
`define USBEC_BIT_TOKEN_EOF  1
`define USBEC_BIT_PID        0
`define USBEC_EP_LOW_SPEED   7
`define USBEC_EP_NAK_RETRY   6
`define USBEC_EP_CTRL_DIS    4
`define USBEC_EP_RX_EN       3
`define USBEC_EP_TX_EN       2
`define USBEC_EP_STALLED     1
`define USBEC_EP_HSHK_EN     0

`endif

// ---- include/usbec_pkg.sv ----
/*
  Types of the USB error and endpoint control block.
  Assumes the defines header is on the include path.
*/
package usbec_pkg;
  typedef enum logic {USBEC_ROLE_DEVICE, USBEC_ROLE_HOST} usbec_role_e;

  typedef struct packed {
    logic stuff;
    logic overrun;
    logic turnaround;
    logic partial;
    logic data_crc;
    logic token_crc;
    logic frame_end;
    logic pid;
  } usbec_err_s;

  typedef struct packed {
    logic       low_speed;
    logic       nak_retry_off;
    logic       rx;
    logic       tx;
    logic       setup_ok;
    logic       handshake;
    logic       stalled;
  } usbec_ep_s;
endpackage

// ---- testbench/usbec_pe_model.sv ----
/*
  Stand-in for the USB protocol engine: pulses error and stall inputs, sets the bytes_over_count level.
  Assumes its tasks are called right after a rising pclk edge.
*/
module usbec_pe_model
  import usbec_pkg::*;
(
  input  wire logic pclk,
  output usbec_err_s  err_event,
  output logic        bytes_over_count,
  output logic        stall_event,
  output logic [3:0]  stall_ep
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    err_event = '0;
    bytes_over_count = 1'b0;
    stall_event = 1'b0;
    stall_ep = 4'h0;
  end

  // One-cycle pulses only, as a real engine reports each detection once.
  task automatic err_pulse(input logic [7:0] e);
    err_event <= usbec_err_s'(e);
    @(posedge pclk);
    err_event <= '0;
  endtask

  // The endpoint number is scrambled once the pulse is gone.
  task automatic stall(input logic [3:0] n);
    stall_ep <= n;
    stall_event <= 1'b1;
    @(posedge pclk);
    stall_event <= 1'b0;
    stall_ep <= ~n;
  endtask

  task automatic over(input logic v);
    bytes_over_count <= v;
  endtask
endmodule

// ---- testbench/testbench.sv ----
/*
  Self-checking bench for the USB error and endpoint control block.
  Assumes the package and the engine model are compiled first.
*/
module testbench
  import usbec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BP[8] = '{0, 1, 1, 2, 3, 4, 5, 7};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, slv;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  usbec_err_s  err_event, err_flags;
  logic        bytes_over_count, stall_event, error_summary_flag;
  logic        bus_reset_irq_enable, detach_irq_enable, store_truncate;
  logic [3:0]  stall_ep;
  usbec_role_e role;
  usbec_ep_s [15:0] ep_ctrl;
  int          num_errors, checks;

  usbec_core #(.EP_COUNT(16)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .err_event(err_event),
    .bytes_over_count(bytes_over_count), .stall_event(stall_event),
    .stall_ep(stall_ep), .err_flags(err_flags),
    .error_summary_flag(error_summary_flag),
    .bus_reset_irq_enable(bus_reset_irq_enable),
    .detach_irq_enable(detach_irq_enable), .store_truncate(store_truncate),
    .role(role), .ep_ctrl(ep_ctrl));
  usbec_pe_model i_pe (.pclk(pclk), .err_event(err_event),
    .bytes_over_count(bytes_over_count), .stall_event(stall_event),
    .stall_ep(stall_ep));

  always #25 pclk = ~pclk;

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch %s expected %0h seen %0h", n, e, g);
    end
  endtask

  // Request held from setup until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n == 20)
      chk("pready", 1, 0);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic t_reset;
    apb(0, 12'h004, 0);
    chk("flags", 0, rd);
    apb(0, 12'h008, 0);
    chk("enables", 0, rd);
    for (int i = 0; i < 16; i++)
    begin
      apb(0, 12'h040 + 12'(4 * i), 0);
      chk("endpoint", 0, rd);
    end
    apb(1, 12'h008, 32'hFFFF_FFFF);
    apb(0, 12'h008, 0);
    chk("enables", 32'h0000_00BF, rd);
    apb(1, 12'h008, 0);
  endtask

  task automatic t_flags;
    for (int k = 0; k < 8; k++)
    begin
      apb(1, 12'h00C, (k == 1) ? 1 : 0);
      i_pe.err_pulse(8'(1 << k));
      repeat (2) @(posedge pclk);
      chk("summary", 0, error_summary_flag);
      chk("err flags", 1 << k, err_flags);
      apb(0, 12'h004, 0);
      chk("flag", 1 << BP[k], rd);
      apb(1, 12'h008, 1 << BP[k]);
      repeat (2) @(posedge pclk);
      chk("summary", 1, error_summary_flag);
      apb(1, 12'h004, 0);
      apb(0, 12'h004, 0);
      chk("flag kept", 1 << BP[k], rd);
      apb(1, 12'h004, 1 << BP[k]);
      apb(0, 12'h004, 0);
      chk("flag cleared", 0, rd);
      apb(1, 12'h008, 0);
    end
  endtask

  // The detection lands on the very edge where the clearing write takes effect.
  task automatic t_race;
    apb(1, 12'h00C, 0);
    fork
      apb(1, 12'h004, 32'h81);
      begin
        repeat (2) @(posedge pclk);
        i_pe.err_pulse(8'h81);
      end
    join
    apb(0, 12'h004, 0);
    chk("event beats clear", 32'h81, rd);
    apb(1, 12'h004, 32'h81);
  endtask

  task automatic t_ep;
    for (int h = 0; h < 2; h++)
    begin
      apb(1, 12'h00C, h);
      apb(1, 12'h040, 32'hFF);
      apb(1, 12'h07C, 32'hFF);
      apb(0, 12'h040, 0);
      chk("ep0", h ? 32'hDF : 32'h1F, rd);
      apb(0, 12'h07C, 0);
      chk("ep15", 32'h1F, rd);
    end
    chk("low speed", 1, ep_ctrl[0].low_speed);
    chk("nak retry off", 1, ep_ctrl[0].nak_retry_off);
    apb(1, 12'h04C, 32'h0D);
    repeat (2) @(posedge pclk);
    chk("setup ok", 1, ep_ctrl[3].setup_ok);
    chk("ep3 ctrl", 7'b001_1110, ep_ctrl[3]);
    apb(1, 12'h04C, 32'h18);
    repeat (2) @(posedge pclk);
    chk("setup ignored", 0, ep_ctrl[3].setup_ok);
    chk("ep3 ctrl", 7'b001_0000, ep_ctrl[3]);
    apb(1, 12'h04C, 32'h1C);
    repeat (2) @(posedge pclk);
    chk("setup barred", 0, ep_ctrl[3].setup_ok);
    chk("ep3 ctrl", 7'b001_1000, ep_ctrl[3]);
    @(posedge pclk);
    i_pe.stall(4'd5);
    apb(0, 12'h054, 0);
    chk("stalled", 32'h02, rd);
  endtask

  task automatic t_misc;
    logic [1:0] irq;
    for (int h = 0; h < 2; h++)
    begin
      apb(1, 12'h00C, h);
      apb(1, 12'h000, 1);
      repeat (2) @(posedge pclk);
      irq = {bus_reset_irq_enable, detach_irq_enable};
      chk("irq enables", h ? 2'b01 : 2'b10, irq);
      chk("role", h, role);
    end
    i_pe.err_pulse(8'h04);
    @(posedge pclk);
    i_pe.over(1'b1);
    i_pe.err_pulse(8'h40);
    repeat (2) @(posedge pclk);
    chk("truncate", 1, store_truncate);
    i_pe.over(1'b0);
    apb(0, 12'h004, 0);
    chk("host flags", 32'h20, rd);
    apb(1, 12'h004, 32'h20);
    apb(1, 12'h020, 32'hFF);
    chk("slverr", 1, slv);
    apb(0, 12'h020, 0);
    chk("unmapped", 32'h1, {rd[30:0], slv});
  endtask

  task automatic end_sim;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_flags();
    t_race();
    t_ep();
    t_misc();
    end_sim();
  end

  // Far beyond the few hundred cycles that the run needs.
  initial
  begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    end_sim();
  end
endmodule
